/* File: src/acc_pkg.sv */
// constants, field layouts and types of the analog comparator control block
// assumes: APB register map of 32-bit aligned words, one clock at 200 MHz
package acc_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_PIN_DISABLE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

    // ****************************************
    // comparator_control_status fields
    // ****************************************
    localparam int BIT_COMPARATOR_OFF = 7;
    localparam int BIT_REFERENCE_SELECT = 6;
    localparam int BIT_COMPARE_RESULT = 5;
    localparam int BIT_EVENT_FLAG = 4;
    localparam int BIT_IRQ_ENABLE = 3;
    localparam int BIT_CAPTURE_ROUTING = 2;
    localparam int BIT_EDGE_MODE_HIGH = 1;
    localparam int BIT_EDGE_MODE_LOW = 0;

    // ****************************************
    // comparator_pin_input_disable fields
    // ****************************************
    localparam int BIT_NEGATIVE_BUFFER_OFF = 1;
    localparam int BIT_POSITIVE_BUFFER_OFF = 0;

    // ****************************************
    // interrupt status and mask fields
    // ****************************************
    localparam int IRQ_BITS = 2;
    localparam int IRQ_BIT_EVENT = 0;
    localparam int IRQ_BIT_TOGGLE = 1;
    localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 2'h0;

    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        EDGE_TOGGLE = 2'h0,
        EDGE_RESERVED = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_RISING = 2'h3
    } acc_edge_mode_t;

endpackage : acc_pkg

/* File: src/acc_evt_if.sv */
// carrier between the control core and the event detector
// assumes: both ends on the system clock
`timescale 1ns/1ps
`default_nettype none
interface acc_evt_if;
    logic result;
    acc_pkg::acc_edge_mode_t mode;
    logic evt;
    modport ctl (output result, output mode, input evt);
    modport det (input result, input mode, output evt);
endinterface : acc_evt_if
`default_nettype wire

/* File: src/acc_sync.sv */
// two-stage synchroniser, one bit per lane
// assumes: inputs asynchronous to clk, reset asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } acc_sync_state_t;

    acc_sync_state_t s;
    acc_sync_state_t next_s;

    // the first stage feeds only the second
    always_comb begin
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;
endmodule : acc_sync
`default_nettype wire

/* File: src/acc_edge_detect.sv */
// event detector: compares current and previous synchronised result
// assumes: result already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module acc_edge_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // event carrier
    acc_evt_if.det ev
);
    typedef struct packed {
        logic prev;
    } acc_edge_state_t;

    acc_edge_state_t s;
    acc_edge_state_t next_s;

    always_comb begin
        next_s.prev = ev.result;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        case (ev.mode)
            acc_pkg::EDGE_TOGGLE: ev.evt = ev.result ^ s.prev; // R10 R14
            acc_pkg::EDGE_FALLING: ev.evt = s.prev & ~ev.result; // R10
            acc_pkg::EDGE_RISING: ev.evt = ~s.prev & ev.result; // R10
            default: ev.evt = 1'b0; // R14
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_falling_only;
        (ev.mode == acc_pkg::EDGE_FALLING) && ev.evt |-> $past(ev.result) && !ev.result;
    endproperty
    a_falling_only: assert property (p_falling_only) else $error("falling event without falling result"); // R10

    property p_rising_seen;
        (ev.mode == acc_pkg::EDGE_RISING) && $rose(ev.result) |-> ev.evt;
    endproperty
    a_rising_seen: assert property (p_rising_seen) else $error("rising result gave no event"); // R6
endmodule : acc_edge_detect
`default_nettype wire

/* File: src/acc_top.sv */
// analog comparator control: settings, result synchroniser, events, interrupts
// assumes: APB master on CLK_SYS; comparator and pin levels asynchronous
//
// How it works
// [R1] result is high while the selected positive input is above the negative pin
// [R2] raw result passes two flip-flops before the readable result bit
// [R3] comparator_off bit 7 powers the comparator down, writable any time
// [R4] software clears irq enable before changing comparator_off
// [R5] reference_select bit 6 chooses bandgap, else positive input pin
// [R6] event flag bit 4 sets on a result change matching the edge mode
// [R7] event flag clears on vector acknowledge or on a written one
// [R8] core request needs flag, irq enable bit 3 and global enable
// [R9] capture_routing bit 2 feeds the result to the timer capture input
// [R10] edge mode: 00 toggle, 01 reserved, 10 falling, 11 rising
// [R11] software clears irq enable before changing edge mode bits
// [R12] software also sets the timer's capture irq enable for capture interrupts
// [R13] buffer-off bits 1 and 0 force the pin's digital read to zero
// [R14] events compare current and previous result; reserved mode sets none
`timescale 1ns/1ps
`default_nettype none
module acc_top (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [31:0] PRDATA,
    // analog comparator
    input wire logic COMPARATOR_RAW,
    output logic COMPARATOR_OFF,
    output logic REFERENCE_SELECT,
    // comparator pins, digital side
    input wire logic POSITIVE_PIN_DIGITAL,
    input wire logic NEGATIVE_PIN_DIGITAL,
    output logic POSITIVE_BUFFER_OFF,
    output logic NEGATIVE_BUFFER_OFF,
    output logic POSITIVE_PIN_READ,
    output logic NEGATIVE_PIN_READ,
    // timer capture front end
    output logic CAPTURE_TRIGGER,
    // core interrupt
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic IRQ_VECTOR_ACK,
    output logic CORE_IRQ_REQ,
    // block interrupt
    output logic IRQ,
    // synchronised result
    output logic COMPARE_RESULT
);
    localparam int IW = acc_pkg::IRQ_BITS;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic comp_off;
        logic ref_sel;
        logic flag;
        logic irq_en;
        logic cap_route;
        acc_pkg::acc_edge_mode_t edge_mode;
        logic pos_buf_off;
        logic neg_buf_off;
        logic [IW-1:0] irq_status;
        logic [IW-1:0] irq_mask;
        logic irq;
        logic core_irq;
        logic cmp_out;
        logic cap_trig;
        logic pos_read;
        logic neg_read;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } acc_top_state_t;

    acc_top_state_t s;
    acc_top_state_t next_s;

    logic rst_n;
    logic [2:0] pin_sync;
    logic result;
    logic setup;
    logic wr_acc;
    logic rd_acc;
    acc_evt_if ev ();

    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    acc_sync #(.WIDTH(1)) u_rst_sync (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .d(1'b1),
        .q(rst_n)
    );

    acc_sync #(.WIDTH(3)) u_pin_sync (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .d({NEGATIVE_PIN_DIGITAL, POSITIVE_PIN_DIGITAL, COMPARATOR_RAW}),
        .q(pin_sync)
    ); // R2

    // a powered-down comparator reads low
    assign result = pin_sync[0] & ~s.comp_off; // R1 R3

    // ****************************************
    // event detection
    // ****************************************
    assign ev.result = result;
    assign ev.mode = s.edge_mode;

    acc_edge_detect u_edge (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .ev(ev)
    ); // R14

    // ****************************************
    // apb decode
    // ****************************************
    assign setup = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & s.pready & PWRITE;
    assign rd_acc = PSEL & PENABLE & s.pready & ~PWRITE;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == acc_pkg::ADDR_CTRL_STATUS) || (a == acc_pkg::ADDR_PIN_DISABLE)
                    || (a == acc_pkg::ADDR_IRQ_STATUS) || (a == acc_pkg::ADDR_IRQ_MASK);
    endfunction : is_mapped

    function automatic logic [31:0] read_image(input acc_top_state_t st, input logic res, input logic [7:0] a);
        read_image = '0;
        case (a)
            acc_pkg::ADDR_CTRL_STATUS: begin
                read_image[acc_pkg::BIT_COMPARATOR_OFF] = st.comp_off;
                read_image[acc_pkg::BIT_REFERENCE_SELECT] = st.ref_sel;
                read_image[acc_pkg::BIT_COMPARE_RESULT] = res;
                read_image[acc_pkg::BIT_EVENT_FLAG] = st.flag;
                read_image[acc_pkg::BIT_IRQ_ENABLE] = st.irq_en;
                read_image[acc_pkg::BIT_CAPTURE_ROUTING] = st.cap_route;
                read_image[acc_pkg::BIT_EDGE_MODE_HIGH:acc_pkg::BIT_EDGE_MODE_LOW] = st.edge_mode;
            end
            acc_pkg::ADDR_PIN_DISABLE: begin
                read_image[acc_pkg::BIT_NEGATIVE_BUFFER_OFF] = st.neg_buf_off;
                read_image[acc_pkg::BIT_POSITIVE_BUFFER_OFF] = st.pos_buf_off;
            end
            acc_pkg::ADDR_IRQ_STATUS: read_image[IW-1:0] = st.irq_status;
            acc_pkg::ADDR_IRQ_MASK: read_image[IW-1:0] = st.irq_mask;
            default: read_image = '0;
        endcase
    endfunction : read_image

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;

        // answer one cycle after setup; read data captured at setup
        next_s.pready = setup;
        next_s.pslverr = setup & ~is_mapped(PADDR);
        next_s.prdata = (setup && !PWRITE) ? read_image(s, result, PADDR) : s.prdata;

        if (wr_acc && PADDR == acc_pkg::ADDR_CTRL_STATUS) begin
            next_s.comp_off = PWDATA[acc_pkg::BIT_COMPARATOR_OFF]; // R3
            next_s.ref_sel = PWDATA[acc_pkg::BIT_REFERENCE_SELECT]; // R5
            next_s.irq_en = PWDATA[acc_pkg::BIT_IRQ_ENABLE];
            next_s.cap_route = PWDATA[acc_pkg::BIT_CAPTURE_ROUTING]; // R9
            next_s.edge_mode = acc_pkg::acc_edge_mode_t'(
                PWDATA[acc_pkg::BIT_EDGE_MODE_HIGH:acc_pkg::BIT_EDGE_MODE_LOW]); // R10
            if (PWDATA[acc_pkg::BIT_EVENT_FLAG]) begin
                next_s.flag = 1'b0; // R7
            end
        end
        if (wr_acc && PADDR == acc_pkg::ADDR_PIN_DISABLE) begin
            next_s.neg_buf_off = PWDATA[acc_pkg::BIT_NEGATIVE_BUFFER_OFF]; // R13
            next_s.pos_buf_off = PWDATA[acc_pkg::BIT_POSITIVE_BUFFER_OFF]; // R13
        end
        if (wr_acc && PADDR == acc_pkg::ADDR_IRQ_MASK) begin
            next_s.irq_mask = PWDATA[IW-1:0];
        end

        // event flag: acknowledge clears, a new event wins
        if (IRQ_VECTOR_ACK) begin
            next_s.flag = 1'b0; // R7
        end
        if (ev.evt) begin
            next_s.flag = 1'b1; // R6
        end

        // sticky status, cleared by a read, set wins
        if (rd_acc && PADDR == acc_pkg::ADDR_IRQ_STATUS) begin
            // bits raised after the setup snapshot stay pending
            next_s.irq_status = s.irq_status & ~s.prdata[IW-1:0];
        end
        if (ev.evt) begin
            next_s.irq_status[acc_pkg::IRQ_BIT_EVENT] = 1'b1;
        end
        if (result != s.cmp_out) begin
            next_s.irq_status[acc_pkg::IRQ_BIT_TOGGLE] = 1'b1;
        end

        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
        next_s.core_irq = next_s.flag & next_s.irq_en & GLOBAL_IRQ_ENABLE; // R8
        next_s.cmp_out = result; // R1 R2
        next_s.cap_trig = next_s.cap_route & result; // R9
        next_s.pos_read = pin_sync[1] & ~next_s.pos_buf_off; // R13
        next_s.neg_read = pin_sync[2] & ~next_s.neg_buf_off; // R13
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.edge_mode <= acc_pkg::EDGE_TOGGLE;
            s.irq_mask <= acc_pkg::IRQ_MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign PRDATA = s.prdata;
    assign COMPARATOR_OFF = s.comp_off; // R3
    assign REFERENCE_SELECT = s.ref_sel; // R5
    assign POSITIVE_BUFFER_OFF = s.pos_buf_off;
    assign NEGATIVE_BUFFER_OFF = s.neg_buf_off;
    assign POSITIVE_PIN_READ = s.pos_read;
    assign NEGATIVE_PIN_READ = s.neg_read;
    assign CAPTURE_TRIGGER = s.cap_trig;
    assign CORE_IRQ_REQ = s.core_irq;
    assign IRQ = s.irq;
    assign COMPARE_RESULT = s.cmp_out;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    sequence s_raw_high_held;
        COMPARATOR_RAW && !s.comp_off;
    endsequence

    property p_result_latency;
        $rose(COMPARATOR_RAW) ##0 s_raw_high_held [*4] |-> COMPARE_RESULT;
    endproperty
    a_result_latency: assert property (p_result_latency) else $error("result not high after sync delay"); // R2

    property p_off_forces_low;
        s.comp_off |=> !COMPARE_RESULT;
    endproperty
    a_off_forces_low: assert property (p_off_forces_low) else $error("result high while comparator off"); // R3

    property p_ref_write;
        wr_acc && PADDR == acc_pkg::ADDR_CTRL_STATUS
            |=> REFERENCE_SELECT == $past(PWDATA[acc_pkg::BIT_REFERENCE_SELECT]);
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("reference select not taken from write"); // R5

    property p_event_sets_flag;
        ev.evt |=> s.flag;
    endproperty
    a_event_sets_flag: assert property (p_event_sets_flag) else $error("event did not set flag"); // R6

    property p_ack_clears_flag;
        s.flag && IRQ_VECTOR_ACK && !ev.evt |=> !s.flag;
    endproperty
    a_ack_clears_flag: assert property (p_ack_clears_flag) else $error("acknowledge did not clear flag"); // R7

    property p_core_request;
        CORE_IRQ_REQ == (s.flag && s.irq_en && $past(GLOBAL_IRQ_ENABLE));
    endproperty
    a_core_request: assert property (p_core_request) else $error("core request mismatch"); // R8

    property p_capture_gate;
        !s.cap_route |-> !CAPTURE_TRIGGER;
    endproperty
    a_capture_gate: assert property (p_capture_gate) else $error("capture driven while not routed"); // R9

    property p_reserved_silent;
        s.edge_mode == acc_pkg::EDGE_RESERVED |-> !ev.evt;
    endproperty
    a_reserved_silent: assert property (p_reserved_silent) else $error("event in reserved mode"); // R14

    property p_buffer_off_reads_zero;
        POSITIVE_BUFFER_OFF |-> !POSITIVE_PIN_READ;
    endproperty
    a_buffer_off_reads_zero: assert property (p_buffer_off_reads_zero) else $error("disabled pin reads one"); // R13

    property p_apb_answer;
        setup |=> PREADY;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no answer one cycle after setup");

    property p_irq_level;
        IRQ == |(s.irq_status & s.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    property p_read_clears_status;
        rd_acc && PADDR == acc_pkg::ADDR_IRQ_STATUS
            && !ev.evt && result == s.cmp_out
            |=> (s.irq_status & $past(s.prdata[IW-1:0])) == '0;
    endproperty
    a_read_clears_status: assert property (p_read_clears_status) else $error("status not cleared");

    property p_toggle_status;
        result != s.cmp_out
            |=> s.irq_status[acc_pkg::IRQ_BIT_TOGGLE];
    endproperty
    a_toggle_status: assert property (p_toggle_status) else $error("toggle lost");

    property p_capture_follows;
        s.cap_route && !wr_acc
            |=> CAPTURE_TRIGGER == $past(result);
    endproperty
    a_capture_follows: assert property (p_capture_follows) else $error("capture mismatch"); // R9

    property p_write_clears_flag;
        wr_acc && PADDR == acc_pkg::ADDR_CTRL_STATUS
            && PWDATA[acc_pkg::BIT_EVENT_FLAG] && !ev.evt
            |=> !s.flag;
    endproperty
    a_write_clears_flag: assert property (p_write_clears_flag) else $error("flag not cleared"); // R7

    property p_neg_off_reads_zero;
        NEGATIVE_BUFFER_OFF |-> !NEGATIVE_PIN_READ;
    endproperty
    a_neg_off_reads_zero: assert property (p_neg_off_reads_zero) else $error("disabled pin reads one"); // R13
endmodule : acc_top
`default_nettype wire

/* File: testbench/acc_analog_model.sv */
// far-side model: analog comparator with its two pins, and a timer capture unit
// assumes: voltages driven by the bench; capture counted on the system clock
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model #(
    parameter real BANDGAP_VOLTS = 1.1,
    parameter real LOGIC_THRESHOLD = 1.5
) (
    // clock
    input wire logic clk,
    // pin voltages
    input var real positive_volts,
    input var real negative_volts,
    // comparator controls
    input wire logic comparator_off,
    input wire logic reference_select,
    output logic comparator_raw,
    // digital pin levels
    output logic positive_pin_digital,
    output logic negative_pin_digital,
    // timer capture unit
    input wire logic capture_trigger,
    input wire logic timer_capture_irq_enable,
    output var int capture_count
);
    real plus_volts;
    logic last_trigger;

    // ****************************************
    // comparator
    // ****************************************
    always_comb begin
        plus_volts = reference_select ? BANDGAP_VOLTS : positive_volts;
        comparator_raw = !comparator_off && (plus_volts > negative_volts);
        positive_pin_digital = positive_volts > LOGIC_THRESHOLD;
        negative_pin_digital = negative_volts > LOGIC_THRESHOLD;
    end

    // ****************************************
    // timer capture: counts rising edges only when its own irq enable is set
    // ****************************************
    initial begin
        capture_count = 0;
        last_trigger = 1'b0;
    end
    always @(posedge clk) begin
        if (timer_capture_irq_enable && capture_trigger && !last_trigger) begin
            capture_count <= capture_count + 1;
        end
        last_trigger <= capture_trigger;
    end
endmodule : acc_analog_model
`default_nettype wire

/* File: testbench/acc_tb_top.sv */
// self-checking bench for the analog comparator control block
// assumes: APB master in the bench, analog side from acc_analog_model
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module acc_tb_top;
    localparam logic [7:0] A_CTRL = acc_pkg::ADDR_CTRL_STATUS;
    localparam logic [7:0] A_PIN = acc_pkg::ADDR_PIN_DISABLE;
    localparam logic [7:0] A_STAT = acc_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] A_MASK = acc_pkg::ADDR_IRQ_MASK;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, raw, comp_off, ref_sel, pos_dig, neg_dig, pos_boff, neg_boff;
    logic pos_read, neg_read, cap_trig, core_req, irq, result;
    logic [31:0] prdata;
    logic global_en = 1'b1;
    logic vec_ack = 1'b0;
    logic timer_en = 1'b0;
    real pos_v = 0.2;
    real neg_v = 0.6;
    int cap_count;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    // ****************************************
    // instances
    // ****************************************
    acc_top i_acc_top (.CLK_SYS(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
        .COMPARATOR_RAW(raw), .COMPARATOR_OFF(comp_off), .REFERENCE_SELECT(ref_sel),
        .POSITIVE_PIN_DIGITAL(pos_dig), .NEGATIVE_PIN_DIGITAL(neg_dig), .POSITIVE_BUFFER_OFF(pos_boff),
        .NEGATIVE_BUFFER_OFF(neg_boff), .POSITIVE_PIN_READ(pos_read), .NEGATIVE_PIN_READ(neg_read),
        .CAPTURE_TRIGGER(cap_trig), .GLOBAL_IRQ_ENABLE(global_en), .IRQ_VECTOR_ACK(vec_ack),
        .CORE_IRQ_REQ(core_req), .IRQ(irq), .COMPARE_RESULT(result));
    acc_analog_model i_acc_analog_model (.clk(clk), .positive_volts(pos_v), .negative_volts(neg_v),
        .comparator_off(comp_off), .reference_select(ref_sel), .comparator_raw(raw),
        .positive_pin_digital(pos_dig), .negative_pin_digital(neg_dig), .capture_trigger(cap_trig),
        .timer_capture_irq_enable(timer_en), .capture_count(cap_count));

    // ****************************************
    // clock, timeout and closing
    // ****************************************
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // apb master and helpers
    // ****************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            stop_test();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHECK(nm, exp, r)
    endtask : rd_chk
    // change pin voltages and let the result settle through the synchroniser
    task automatic drive(input real p, input real n);
        @(posedge clk);
        pos_v <= p;
        neg_v <= n;
        repeat (6) @(posedge clk);
        #1;
    endtask : drive

    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [31:0] r;
        logic e;
        int c;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(A_CTRL, 32'h0, "ctrl reset");
        rd_chk(A_PIN, 32'h0, "pin disable reset");
        rd_chk(A_STAT, 32'h0, "status reset");
        rd_chk(A_MASK, 32'h0, "mask reset");
        apb(1'b0, 8'h10, 32'h0, r, e);
        `CHECK("unmapped error", 1'b1, e)
        `CHECK("unmapped data", 32'h0, r)
        // synchroniser latency
        @(posedge clk);
        pos_v <= 1.0;
        @(posedge clk);
        #1 `CHECK("result early", 1'b0, result)
        repeat (3) @(posedge clk);
        #1 `CHECK("result late", 1'b1, result)
        rd_chk(A_CTRL, 32'h30, "ctrl result");
        drive(0.2, 0.6);
        // every edge mode, irq enable kept clear while the mode changes
        for (int m = 0; m < 4; m++) begin
            wr(A_CTRL, 32'h10 | m);
            drive(1.0, 0.6);
            rd_chk(A_CTRL, 32'h20 | m | ((m == 0 || m == 3) ? 32'h10 : 32'h0), "flag on rise");
            wr(A_CTRL, 32'h10 | m);
            drive(0.2, 0.6);
            rd_chk(A_CTRL, m | ((m == 0 || m == 2) ? 32'h10 : 32'h0), "flag on fall");
        end
        // block interrupt: sticky status, mask, read clears
        wr(A_CTRL, 32'h13);
        wr(A_MASK, 32'h1);
        rd_chk(A_MASK, 32'h1, "mask readback");
        apb(1'b0, A_STAT, 32'h0, r, e);
        drive(1.0, 0.6);
        `CHECK("irq raised", 1'b1, irq)
        rd_chk(A_STAT, 32'h3, "status event");
        repeat (2) @(posedge clk);
        #1 `CHECK("irq after read", 1'b0, irq)
        rd_chk(A_STAT, 32'h0, "status cleared");
        wr(A_MASK, 32'h0);
        drive(0.2, 0.6);
        `CHECK("irq masked", 1'b0, irq)
        rd_chk(A_STAT, 32'h2, "status toggle only");
        wr(A_MASK, 32'h2);
        drive(1.0, 0.6);
        `CHECK("irq toggle", 1'b1, irq)
        rd_chk(A_STAT, 32'h3, "status both");
        // core request, vector acknowledge and written clear
        wr(A_CTRL, 32'h13);
        drive(0.2, 0.6);
        wr(A_CTRL, 32'h0b);
        drive(1.0, 0.6);
        `CHECK("core request", 1'b1, core_req)
        @(posedge clk);
        vec_ack <= 1'b1;
        @(posedge clk);
        vec_ack <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHECK("core request acked", 1'b0, core_req)
        rd_chk(A_CTRL, 32'h2b, "flag acked");
        global_en <= 1'b0;
        drive(0.2, 0.6);
        drive(1.0, 0.6);
        `CHECK("core request gated", 1'b0, core_req)
        rd_chk(A_CTRL, 32'h3b, "flag without global");
        wr(A_CTRL, 32'h1b);
        rd_chk(A_CTRL, 32'h2b, "flag written clear");
        global_en <= 1'b1;
        // comparator off, irq enable cleared first
        wr(A_CTRL, 32'h03);
        wr(A_CTRL, 32'h80);
        repeat (4) @(posedge clk);
        #1 `CHECK("comparator off", 1'b1, comp_off)
        `CHECK("result while off", 1'b0, result)
        rd_chk(A_CTRL, 32'h90, "ctrl off");
        // reference select
        wr(A_CTRL, 32'h40);
        drive(2.0, 1.3);
        `CHECK("reference select", 1'b1, ref_sel)
        `CHECK("result bandgap", 1'b0, result)
        wr(A_CTRL, 32'h0);
        repeat (5) @(posedge clk);
        #1 `CHECK("result pin", 1'b1, result)
        // capture routing
        timer_en <= 1'b1;
        wr(A_CTRL, 32'h04);
        drive(0.2, 0.6);
        c = cap_count;
        `CHECK("capture low", 1'b0, cap_trig)
        drive(1.0, 0.6);
        `CHECK("capture high", 1'b1, cap_trig)
        `CHECK("capture count", c + 1, cap_count)
        wr(A_CTRL, 32'h0);
        drive(0.2, 0.6);
        drive(1.0, 0.6);
        `CHECK("capture unrouted", 1'b0, cap_trig)
        `CHECK("capture count held", c + 1, cap_count)
        // digital input buffers
        drive(2.0, 1.8);
        `CHECK("positive pin read", 1'b1, pos_read)
        `CHECK("negative pin read", 1'b1, neg_read)
        wr(A_PIN, 32'h3);
        rd_chk(A_PIN, 32'h3, "pin disable readback");
        repeat (3) @(posedge clk);
        #1 `CHECK("positive buffer off", 1'b1, pos_boff)
        `CHECK("negative buffer off", 1'b1, neg_boff)
        `CHECK("positive pin zero", 1'b0, pos_read)
        `CHECK("negative pin zero", 1'b0, neg_read)
        wr(A_PIN, 32'h2);
        repeat (3) @(posedge clk);
        #1 `CHECK("positive pin back", 1'b1, pos_read)
        `CHECK("negative pin still zero", 1'b0, neg_read)
        stop_test();
    end
endmodule : acc_tb_top
`default_nettype wire
